// ===== verilog/irq_pkg.sv
// Purpose: shared constants and types for the maskable interrupt request logic
// Assumes: one core_clk domain, synchronous active-low reset, 8 sources
// Notes:   control byte = {2'b0, sel, pol, pending, level[2:0]}
// How it works
// (R1) acknowledge read of zero returns number, level
// (R2) acknowledge clears the acknowledged pending flag
// (R3) program read of zero also clears highest
// (R4) source, polarity or timing change may set pending
// (R5) software clears pending after changing a source
// (R6) mask by global flag or level field first
// (R7) filtered source: wait three samples before clearing
// (R8) each procedure step is its own write
// (R9) rewrite control only while interrupt cannot request
// (R10) plain store may lose a coinciding request
// (R11) clear pending only with a plain move write
// (R12) wait for write completion before re-enabling interrupts
// (R13) pending holds until acknowledge, clear or read
package irq_pkg;
	localparam int          num_src      = 8;
	localparam int          chan_w       = 3;
	typedef logic [7:0]  byte_t;
	typedef logic [15:0] addr_t;

	localparam addr_t vector_addr                     = 16'h0000;
	localparam addr_t ctrl_base_addr                  = 16'h0050;
	localparam addr_t timer_j0_interrupt_control_addr = 16'h0056;

	localparam int    lvl_lsb   = 0;
	localparam int    pend_bit  = 3;
	localparam int    pol_bit   = 4;
	localparam int    sel_bit   = 5;
	localparam byte_t lvl_mask  = 8'h07;
	localparam byte_t pend_mask = 8'h08;
	localparam byte_t src_mask  = 8'h30;
	localparam byte_t used_mask = 8'h3f;
	localparam byte_t ctrl_reset = 8'h00;

	localparam int vec_found_bit = 7;
	localparam int vec_num_lsb   = 3;

	localparam logic [2:0] cpu_ipl = 3'h0;

	localparam logic [7:0] settle_cycles      = 8'h02;
	localparam logic [7:0] filter_periods     = 8'h03;
	localparam logic [7:0] filt_sample_cycles = 8'h04;
	localparam logic [7:0] filt_wait_cycles   = 8'(filter_periods * filt_sample_cycles);

	typedef enum logic [1:0] {kind_read, kind_ack, kind_move, kind_rmw} bus_kind_e;
	typedef enum logic [2:0] {op_read, op_write, op_set_bits, op_clear_flag, op_change_src} host_op_e;
endpackage

// ===== verilog/irq_bus_if.sv
// Purpose: link between interrupt controller and cpu core
// Assumes: single request per cycle, read data one cycle later
// Notes:   no stall; every request is taken
`timescale 1ns/1ps
interface irq_bus_if (
	input wire logic core_clk,
	input wire logic reset_n
);
	import irq_pkg::*;
	logic              req;
	bus_kind_e         kind;
	addr_t             addr;
	byte_t             wdata;
	byte_t             wmask;
	logic              rvalid;
	byte_t             rdata;
	logic              irq_req;
	logic [2:0]        irq_level;

	modport ctrl (input core_clk, reset_n, req, kind, addr, wdata, wmask,
		output rvalid, rdata, irq_req, irq_level);
	modport core (input core_clk, reset_n, rvalid, rdata, irq_req, irq_level,
		output req, kind, addr, wdata, wmask);
endinterface

// ===== verilog/intc_ctrl.sv
// Purpose: per-source control bytes, priority pick, vector read at zero
// Assumes: sources synchronous to core_clk
// Notes:   requests are rising edges of the selected, polarity-adjusted source
`timescale 1ns/1ps
module intc_ctrl (
	// link to cpu core
	irq_bus_if.ctrl                 bus,
	// peripheral request sources
	input  wire logic [7:0]         src_a,
	input  wire logic [7:0]         src_b,
	// pending flags view
	output logic [7:0]              pend_out
);
	import irq_pkg::*;

	byte_t             ctrl_reg [num_src];
	logic [num_src-1:0] eff_reg;
	logic              rvalid_reg;
	byte_t             rdata_reg;
	logic              irq_req_reg;
	logic [2:0]        irq_level_reg;

	logic              found;
	logic [2:0]        best_lvl;
	logic [chan_w-1:0] best_num;
	logic [num_src-1:0] ack_clr;

	wire               vec_rd   = bus.req && bus.addr == vector_addr &&
		(bus.kind == kind_ack || bus.kind == kind_read);
	wire addr_t        off      = bus.addr - ctrl_base_addr;
	wire               ctrl_hit = bus.req && off < addr_t'(num_src);
	wire [chan_w-1:0]  idx      = off[chan_w-1:0];
	wire               is_move  = bus.kind == kind_move;
	wire               is_rmw   = bus.kind == kind_rmw;
	wire byte_t        rd_next  = vec_rd ? {found, 1'b0, best_num, best_lvl} :
		(ctrl_hit && bus.kind == kind_read) ? (ctrl_reg[idx] & used_mask) : 8'h00;

	// highest level wins, lower number breaks ties
	always_comb begin
		found    = 1'b0;
		best_lvl = 3'h0;
		best_num = '0;
		for (int i = 0; i < num_src; i++) begin
			if (ctrl_reg[i][pend_bit] && ctrl_reg[i][2:0] > best_lvl) begin
				found    = 1'b1;
				best_lvl = ctrl_reg[i][2:0];
				best_num = chan_w'(i);
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < num_src; g++) begin : chan
			wire        eff   = (ctrl_reg[g][sel_bit] ? src_b[g] : src_a[g]) ^ ctrl_reg[g][pol_bit];
			wire        evt   = eff && !eff_reg[g]; // R4
			wire        hit   = ctrl_hit && idx == chan_w'(g);
			wire byte_t cur   = ctrl_reg[g];
			wire byte_t merge = (cur & ~bus.wmask) | (bus.wdata & bus.wmask);
			// plain store takes the flag as written; coinciding edge dropped
			wire byte_t mv    = bus.wdata & used_mask; // R10 R11
			// read-modify-write never clears the flag and keeps a new edge
			wire byte_t rmw   = (merge & ~pend_mask) | (cur & pend_mask) | (evt ? pend_mask : 8'h00); // R10
			// set wins over acknowledge clear
			wire byte_t keep  = (cur & ~pend_mask) |
				((evt || (cur[pend_bit] && !ack_clr[g])) ? pend_mask : 8'h00); // R2 R3 R13
			wire byte_t nxt   = (hit && is_move) ? mv : (hit && is_rmw) ? (rmw & used_mask) : keep;
			assign ack_clr[g] = vec_rd && found && best_num == chan_w'(g); // R2 R3
			assign pend_out[g] = ctrl_reg[g][pend_bit];
			always_ff @(posedge bus.core_clk) begin
				if (!bus.reset_n) begin
					ctrl_reg[g] <= ctrl_reset;
					eff_reg[g]  <= 1'b0;
				end else begin
					ctrl_reg[g] <= nxt;
					eff_reg[g]  <= eff;
				end
			end
		end
	endgenerate

	always_ff @(posedge bus.core_clk) begin
		if (!bus.reset_n) begin
			rvalid_reg    <= 1'b0;
			rdata_reg     <= 8'h00;
			irq_req_reg   <= 1'b0;
			irq_level_reg <= 3'h0;
		end else begin
			rvalid_reg    <= bus.req && (bus.kind == kind_read || bus.kind == kind_ack);
			rdata_reg     <= rd_next; // R1
			irq_req_reg   <= found;
			irq_level_reg <= best_lvl;
		end
	end

	assign bus.rvalid    = rvalid_reg;
	assign bus.rdata     = rdata_reg;
	assign bus.irq_req   = irq_req_reg;
	assign bus.irq_level = irq_level_reg;
endmodule

// ===== verilog/core_end.sv
// Purpose: cpu core side: acknowledge cycles and safe control rewrite sequences
// Assumes: controller answers reads one cycle after the request
// Notes:   commands win over acknowledge when both are due in idle
`timescale 1ns/1ps
module core_end (
	// link to interrupt controller
	irq_bus_if.core                 bus,
	// software command port
	input  wire logic               cmd_valid,
	input  irq_pkg::host_op_e       cmd_op,
	input  wire logic [2:0]         cmd_chan,
	input  irq_pkg::byte_t          cmd_data,
	input  irq_pkg::byte_t          cmd_mask,
	input  wire logic               cmd_global,
	input  wire logic               cmd_filter,
	output logic                    cmd_ready,
	output logic                    cmd_done,
	output irq_pkg::byte_t          rd_data,
	// global enable wish and state
	input  wire logic               int_enable,
	output logic                    i_flag,
	output logic                    periph_disable,
	// acknowledged interrupt
	output logic                    ack_valid,
	output logic [2:0]              ack_number,
	output logic [2:0]              ack_level
);
	import irq_pkg::*;

	typedef enum {st_idle, st_ack_wait, st_rd_wait, st_mask_wait, st_src_wr, st_filt,
		st_clr_rd, st_clr_wait, st_lvl_wr, st_wr, st_settle} state_e;

	state_e     state_reg, state_next;
	host_op_e   op_reg, op_next;
	addr_t      caddr_reg, caddr_next;
	byte_t      data_reg, data_next;
	byte_t      mask_reg, mask_next;
	logic       global_reg, global_next;
	logic       filter_reg, filter_next;
	logic [2:0] lvl_reg, lvl_next;
	logic [7:0] cnt_reg, cnt_next;
	logic       i_reg, i_next;
	logic       periph_reg, periph_next;
	logic       req_reg, req_next;
	bus_kind_e  kind_reg, kind_next;
	addr_t      addr_reg, addr_next;
	byte_t      wdata_reg, wdata_next;
	byte_t      wmask_reg, wmask_next;
	logic       ready_reg, ready_next;
	logic       done_reg, done_next;
	byte_t      rd_reg, rd_next;
	logic       ackv_reg, ackv_next;
	logic [2:0] ackn_reg, ackn_next;
	logic [2:0] ackl_reg, ackl_next;

	wire addr_t cmd_addr = ctrl_base_addr + addr_t'(cmd_chan);
	wire        ack_due  = i_reg && bus.irq_req && bus.irq_level > cpu_ipl;
	wire        filt_end = cnt_reg == 8'h01;

	always_comb begin
		state_next  = state_reg;
		op_next     = op_reg;
		caddr_next  = caddr_reg;
		data_next   = data_reg;
		mask_next   = mask_reg;
		global_next = global_reg;
		filter_next = filter_reg;
		lvl_next    = lvl_reg;
		cnt_next    = cnt_reg;
		i_next      = i_reg;
		periph_next = periph_reg;
		req_next    = 1'b0;
		kind_next   = kind_reg;
		addr_next   = addr_reg;
		wdata_next  = wdata_reg;
		wmask_next  = wmask_reg;
		done_next   = 1'b0;
		rd_next     = rd_reg;
		ackv_next   = 1'b0;
		ackn_next   = ackn_reg;
		ackl_next   = ackl_reg;
		unique case (state_reg)
			st_idle: begin
				i_next = int_enable;
				if (cmd_valid && ready_reg) begin
					op_next     = cmd_op;
					caddr_next  = cmd_addr;
					data_next   = cmd_data;
					mask_next   = cmd_mask;
					global_next = cmd_global;
					filter_next = cmd_filter;
					unique case (cmd_op)
						op_read: begin
							// reads only target control bytes, never address zero
							req_next   = 1'b1; // R3
							kind_next  = kind_read;
							addr_next  = cmd_addr;
							state_next = st_rd_wait;
						end
						op_write, op_set_bits: begin
							i_next     = 1'b0; // R9
							state_next = st_wr;
						end
						op_clear_flag: begin
							i_next     = 1'b0; // R9
							state_next = st_clr_rd;
						end
						op_change_src: begin
							periph_next = 1'b1; // R6
							if (cmd_global) begin
								i_next     = 1'b0; // R6
								state_next = st_src_wr;
							end else begin
								req_next   = 1'b1;
								kind_next  = kind_read;
								addr_next  = cmd_addr;
								state_next = st_mask_wait;
							end
						end
					endcase
				end else if (ack_due) begin
					req_next   = 1'b1;
					kind_next  = kind_ack;
					addr_next  = vector_addr;
					state_next = st_ack_wait;
				end
			end
			st_ack_wait: begin
				if (bus.rvalid) begin
					ackv_next  = bus.rdata[vec_found_bit]; // R1
					ackn_next  = bus.rdata[vec_num_lsb +: 3];
					ackl_next  = bus.rdata[lvl_lsb +: 3];
					state_next = st_idle;
				end
			end
			st_rd_wait: begin
				if (bus.rvalid) begin
					rd_next    = bus.rdata;
					done_next  = 1'b1;
					state_next = st_idle;
				end
			end
			st_mask_wait: begin
				// level field to zero masks this source alone
				if (bus.rvalid) begin
					lvl_next   = bus.rdata[lvl_lsb +: 3];
					req_next   = 1'b1; // R6
					kind_next  = kind_rmw;
					addr_next  = caddr_reg;
					wdata_next = 8'h00;
					wmask_next = lvl_mask;
					state_next = st_src_wr;
				end
			end
			st_src_wr: begin
				req_next   = 1'b1; // R8
				kind_next  = kind_rmw;
				addr_next  = caddr_reg;
				wdata_next = data_reg & src_mask;
				wmask_next = src_mask;
				cnt_next   = filt_wait_cycles;
				state_next = filter_reg ? st_filt : st_clr_rd;
			end
			st_filt: begin
				// filter needs three sample periods before the flag settles
				cnt_next = cnt_reg - 8'h01; // R7
				if (filt_end) begin
					state_next = st_clr_rd;
				end
			end
			st_clr_rd: begin
				req_next   = 1'b1;
				kind_next  = kind_read;
				addr_next  = caddr_reg;
				state_next = st_clr_wait;
			end
			st_clr_wait: begin
				if (bus.rvalid) begin
					req_next   = 1'b1;
					kind_next  = kind_move; // R11
					addr_next  = caddr_reg;
					wdata_next = bus.rdata & ~pend_mask; // R5
					wmask_next = 8'hff;
					cnt_next   = settle_cycles;
					state_next = (op_reg == op_change_src && !global_reg) ? st_lvl_wr : st_settle;
				end
			end
			st_lvl_wr: begin
				req_next   = 1'b1; // R8
				kind_next  = kind_rmw;
				addr_next  = caddr_reg;
				wdata_next = {5'h00, lvl_reg};
				wmask_next = lvl_mask;
				cnt_next   = settle_cycles;
				state_next = st_settle;
			end
			st_wr: begin
				req_next   = 1'b1;
				kind_next  = (op_reg == op_write) ? kind_move : kind_rmw;
				addr_next  = caddr_reg;
				wdata_next = data_reg;
				wmask_next = (op_reg == op_write) ? 8'hff : mask_reg;
				cnt_next   = settle_cycles;
				state_next = st_settle;
			end
			st_settle: begin
				// keep interrupts off until the last write has landed
				cnt_next = cnt_reg - 8'h01; // R12
				if (cnt_reg == 8'h01) begin
					periph_next = 1'b0;
					done_next   = 1'b1;
					state_next  = st_idle;
				end
			end
		endcase
		ready_next = state_next == st_idle;
	end

	always_ff @(posedge bus.core_clk) begin
		if (!bus.reset_n) begin
			state_reg  <= st_idle;
			op_reg     <= op_read;
			caddr_reg  <= ctrl_base_addr;
			data_reg   <= 8'h00;
			mask_reg   <= 8'h00;
			global_reg <= 1'b0;
			filter_reg <= 1'b0;
			lvl_reg    <= 3'h0;
			cnt_reg    <= 8'h00;
			i_reg      <= 1'b0;
			periph_reg <= 1'b0;
		end else begin
			state_reg  <= state_next;
			op_reg     <= op_next;
			caddr_reg  <= caddr_next;
			data_reg   <= data_next;
			mask_reg   <= mask_next;
			global_reg <= global_next;
			filter_reg <= filter_next;
			lvl_reg    <= lvl_next;
			cnt_reg    <= cnt_next;
			i_reg      <= i_next;
			periph_reg <= periph_next;
		end
	end

	always_ff @(posedge bus.core_clk) begin
		if (!bus.reset_n) begin
			req_reg   <= 1'b0;
			kind_reg  <= kind_read;
			addr_reg  <= 16'h0000;
			wdata_reg <= 8'h00;
			wmask_reg <= 8'h00;
			ready_reg <= 1'b0;
			done_reg  <= 1'b0;
			rd_reg    <= 8'h00;
			ackv_reg  <= 1'b0;
			ackn_reg  <= 3'h0;
			ackl_reg  <= 3'h0;
		end else begin
			req_reg   <= req_next;
			kind_reg  <= kind_next;
			addr_reg  <= addr_next;
			wdata_reg <= wdata_next;
			wmask_reg <= wmask_next;
			ready_reg <= ready_next;
			done_reg  <= done_next;
			rd_reg    <= rd_next;
			ackv_reg  <= ackv_next;
			ackn_reg  <= ackn_next;
			ackl_reg  <= ackl_next;
		end
	end

	assign bus.req        = req_reg;
	assign bus.kind       = kind_reg;
	assign bus.addr       = addr_reg;
	assign bus.wdata      = wdata_reg;
	assign bus.wmask      = wmask_reg;
	assign cmd_ready      = ready_reg;
	assign cmd_done       = done_reg;
	assign rd_data        = rd_reg;
	assign i_flag         = i_reg;
	assign periph_disable = periph_reg;
	assign ack_valid      = ackv_reg;
	assign ack_number     = ackn_reg;
	assign ack_level      = ackl_reg;
endmodule

// ===== dv/irq_bus_assertions.sv
// Purpose: concurrent checks on the controller to core link
// Assumes: one core_clk domain, synchronous active-low reset
// Notes:   sees the link signals only, never the sources
`timescale 1ns/1ps
module irq_bus_assertions (
	// clock and reset
	input wire logic        core_clk,
	input wire logic        reset_n,
	// core requests
	input wire logic        req,
	input irq_pkg::bus_kind_e kind,
	input irq_pkg::addr_t   addr,
	input irq_pkg::byte_t   wdata,
	input irq_pkg::byte_t   wmask,
	// controller answers
	input wire logic        rvalid,
	input irq_pkg::byte_t   rdata,
	input wire logic        irq_req,
	input wire logic [2:0]  irq_level
);
	import irq_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	sequence read_req;
		req && (kind == kind_read || kind == kind_ack);
	endsequence
	sequence vec_req;
		req && (kind == kind_read || kind == kind_ack) && addr == vector_addr;
	endsequence
	sequence ctrl_req;
		req && kind == kind_read && addr >= ctrl_base_addr && addr < ctrl_base_addr + 16'h0008;
	endsequence

	a_read_answer: assert property (read_req |=> rvalid)
		else $error("read without answer");
	a_write_silent: assert property (req && (kind == kind_move || kind == kind_rmw) |=> !rvalid)
		else $error("write gave an answer");
	a_answer_cause: assert property (rvalid |-> $past(req) && ($past(kind) == kind_read || $past(kind) == kind_ack))
		else $error("answer without read");
	a_rdata_quiet: assert property (!rvalid |-> rdata == 8'h00)
		else $error("read data outside answer");
	a_vector_format: assert property (vec_req |=> !rdata[6] && (!rdata[vec_found_bit] || rdata[2:0] != 3'h0))
		else $error("bad vector byte");
	a_level_agree: assert property (irq_req == (irq_level != 3'h0))
		else $error("request and level disagree");
	a_ctrl_top: assert property (ctrl_req |=> rdata[7:6] == 2'b00)
		else $error("control byte top bits set");
	a_fall_cause: assert property ($fell(irq_req) |-> $past(req, 2))
		else $error("request dropped without access");
endmodule

// ===== dv/tb_maskable_interrupt_request_logic.sv
// Purpose: bench joining controller and core end over the link
// Assumes: sources stay low unless a test drives them
// Notes:   driver queues expected results, monitor pops on each result
`timescale 1ns/1ps
module tb_maskable_interrupt_request_logic;
	import irq_pkg::*;
	typedef struct packed {logic chk; byte_t val;} note_s;
	logic        core_clk, reset_n, cmd_valid, cmd_global, cmd_filter, int_enable;
	logic        cmd_ready, cmd_done, i_flag, periph_disable, ack_valid;
	logic [7:0]  src_a, src_b, pend_out;
	logic [2:0]  cmd_chan, ack_number, ack_level, ch;
	host_op_e    cmd_op;
	byte_t       cmd_data, cmd_mask, rd_data, val;
	note_s       rd_q[$];
	note_s       note;
	byte_t       ack_q[$];
	int          error_cnt, checks_done, cycles;
	integer      seed;

	irq_bus_if i_irq_bus_if (.core_clk(core_clk), .reset_n(reset_n));
	intc_ctrl i_intc_ctrl (.bus(i_irq_bus_if), .src_a(src_a), .src_b(src_b), .pend_out(pend_out));
	core_end i_core_end (.bus(i_irq_bus_if), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_chan(cmd_chan),
		.cmd_data(cmd_data), .cmd_mask(cmd_mask), .cmd_global(cmd_global), .cmd_filter(cmd_filter),
		.cmd_ready(cmd_ready), .cmd_done(cmd_done), .rd_data(rd_data), .int_enable(int_enable),
		.i_flag(i_flag), .periph_disable(periph_disable), .ack_valid(ack_valid),
		.ack_number(ack_number), .ack_level(ack_level));
	irq_bus_assertions i_irq_bus_assertions (.core_clk(core_clk), .reset_n(reset_n),
		.req(i_irq_bus_if.req), .kind(i_irq_bus_if.kind), .addr(i_irq_bus_if.addr),
		.wdata(i_irq_bus_if.wdata), .wmask(i_irq_bus_if.wmask), .rvalid(i_irq_bus_if.rvalid),
		.rdata(i_irq_bus_if.rdata), .irq_req(i_irq_bus_if.irq_req), .irq_level(i_irq_bus_if.irq_level));

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	task automatic check_val(input byte_t seen, input byte_t exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// one command start to finish; ready is polled at edges
	task automatic cmd(input host_op_e op, input logic [2:0] c, input byte_t d, input byte_t m,
		input logic g, input logic f, input logic chk, input byte_t exp);
		rd_q.push_back({chk, exp});
		@(posedge core_clk);
		while (cmd_ready !== 1'b1) @(posedge core_clk);
		#1;
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_chan = c;
		cmd_data = d;
		cmd_mask = m;
		cmd_global = g;
		cmd_filter = f;
		@(posedge core_clk);
		#1;
		cmd_valid = 1'b0;
		@(posedge core_clk);
		#1;
		check_val({7'h00, periph_disable}, {7'h00, op == op_change_src});
		// writes drop the i flag at once; a level-masked source change keeps it
		check_val({7'h00, i_flag}, {7'h00, int_enable && (op == op_read || (op == op_change_src && !g))});
		@(posedge core_clk);
		while (cmd_done !== 1'b1) @(posedge core_clk);
		// still masked on the done edge: the last write must land first
		check_val({7'h00, i_flag}, {7'h00, int_enable && (op == op_read || (op == op_change_src && !g))});
	endtask

	always @(posedge core_clk) begin
		if (reset_n === 1'b1 && cmd_done === 1'b1) begin
			note = rd_q.pop_front();
			if (note.chk)
				check_val(rd_data, note.val);
		end
		if (reset_n === 1'b1 && ack_valid === 1'b1)
			check_val({2'b00, ack_number, ack_level}, ack_q.pop_front());
	end

	// whole run needs under two thousand cycles
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 6000) begin
			error_cnt++;
			$display("mismatch at %0t: timeout", $time);
			results();
		end
	end

	initial begin
		seed = 32'hae15;
		{cmd_valid, cmd_global, cmd_filter, int_enable, src_a, src_b} = '0;
		{cmd_chan, cmd_data, cmd_mask} = '0;
		cmd_op = op_read;
		reset_n = 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
		reset_n = 1'b1;
		for (int c = 0; c < 8; c++)
			cmd(op_read, c[2:0], 8'h00, 8'h00, 1'b0, 1'b0, 1'b1, ctrl_reset);
		$display("test reset_values done");
		// source bits left alone so writes make no edges
		repeat (16) begin
			val = 8'($random(seed)) & 8'h0f;
			ch = 3'($random(seed));
			cmd(op_write, ch, val, 8'h00, 1'b0, 1'b0, 1'b0, 8'h00);
			repeat (5) @(posedge core_clk);
			cmd(op_read, ch, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1, val);
		end
		for (int c = 0; c < 8; c++)
			cmd(op_write, c[2:0], 8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 8'h00);
		$display("test random_writes done");
		cmd(op_write, 3'h6, 8'h0f, 8'h00, 1'b0, 1'b0, 1'b0, 8'h00);
		cmd(op_set_bits, 3'h6, 8'h02, 8'h3f, 1'b0, 1'b0, 1'b0, 8'h00);
		cmd(op_read, 3'h6, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1, 8'h0a);
		cmd(op_clear_flag, 3'h6, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 8'h00);
		cmd(op_read, 3'h6, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1, 8'h02);
		$display("test bit_ops done");
		#1;
		src_a[2] = 1'b1;
		repeat (3) @(posedge core_clk);
		check_val(pend_out, 8'h04);
		cmd(op_read, 3'h2, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1, 8'h08);
		cmd(op_clear_flag, 3'h2, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 8'h00);
		cmd(op_read, 3'h2, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1, 8'h00);
		$display("test source_edge done");
		// polarity flip makes an edge that the procedure must clear
		cmd(op_write, 3'h3, 8'h05, 8'h00, 1'b0, 1'b0, 1'b0, 8'h00);
		cmd(op_change_src, 3'h3, 8'h30, 8'h30, 1'b1, 1'b0, 1'b0, 8'h00);
		cmd(op_read, 3'h3, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1, 8'h35);
		// level-masked change through the filter wait
		cmd(op_write, 3'h4, 8'h04, 8'h00, 1'b0, 1'b0, 1'b0, 8'h00);
		cmd(op_change_src, 3'h4, 8'h10, 8'h30, 1'b0, 1'b1, 1'b0, 8'h00);
		cmd(op_read, 3'h4, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1, 8'h14);
		$display("test change_source done");
		cmd(op_write, 3'h5, 8'h03, 8'h00, 1'b0, 1'b0, 1'b0, 8'h00);
		cmd(op_write, 3'h1, 8'h06, 8'h00, 1'b0, 1'b0, 1'b0, 8'h00);
		ack_q.push_back(8'h0e);
		ack_q.push_back(8'h2b);
		#1;
		src_a = src_a | 8'h22;
		repeat (3) @(posedge core_clk);
		#1;
		int_enable = 1'b1;
		while (ack_q.size() != 0) @(posedge core_clk);
		cmd(op_read, 3'h1, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1, 8'h06);
		cmd(op_read, 3'h5, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1, 8'h03);
		$display("test acknowledge done");
		// write with interrupts wanted on: i flag must stay low until the write settles
		cmd(op_write, 3'h7, 8'h02, 8'h00, 1'b0, 1'b0, 1'b0, 8'h00);
		cmd(op_read, 3'h7, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1, 8'h02);
		$display("test masking done");
		results();
	end
endmodule
